// ===== scp_params.svh
// Purpose: constants of the serial configuration memory reader
// Assumes: included by its bare name from the fifo and reader design files
// Notes: definitions only
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH

// stored stream length in bits
`define SCP_MEM_BITS 65536
// width of one word from the backing store
`define SCP_WORD_W 8
// words buffered between backing store and serial output
`define SCP_FIFO_DEPTH 32
// stages on every asynchronous pin input
`define SCP_SYNC_STAGES 3
// pin bit positions in the synchroniser vector
`define SCP_PIN_CLK 0
`define SCP_PIN_CE 1
`define SCP_PIN_RST 2
`define SCP_PIN_POL 3
`define SCP_PIN_COUNT 4

`endif

// ===== scp_pkg.sv
// Purpose: types shared by the serial configuration memory reader
// Assumes: nothing
// Notes: pins travel together as one packed struct
package scp_pkg;

    typedef struct packed {
        logic link_clk;
        logic chip_sel_n;
        logic reset_oe;
        logic reset_pol_high;
    } scp_pins_s;

    typedef enum logic [3:0] {
        ST_HOLD = 4'h1,
        ST_FETCH = 4'h2,
        ST_SEND = 4'h4,
        ST_DONE = 4'h8
    } scp_state_e;

endpackage

// ===== scp_fifo.sv
// Purpose: word buffer with registered read data
// Assumes: DEPTH is a power of two
// Notes: in_ready is registered; flush empties in one cycle
`include "scp_params.svh"

module scp_fifo #(
    parameter int WIDTH = `SCP_WORD_W,
    parameter int DEPTH = `SCP_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic flush,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [CW-1:0] next_count;
    logic next_in_ready;
    logic next_out_valid;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        push = in_valid & in_ready;
        pop = (count != '0) & (~out_valid | out_ready);
        next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
        next_count = CW'(count + CW'(push) - CW'(pop));
        next_out_valid = pop | (out_valid & ~out_ready);
        if (flush)
        begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count = '0;
            next_out_valid = 1'b0;
        end
        // ready looks one word ahead so it can come from a flop
        next_in_ready = next_count < CW'(DEPTH);
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            in_ready <= next_in_ready;
            out_valid <= next_out_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // storage and read register carry no reset
    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
        if (pop)
        begin
            out_data <= mem[rd_ptr];
        end
    end

endmodule // scp_fifo

// ===== scp_reader.sv
// Purpose: read side of a bit-serial configuration memory
// Assumes: link pins are asynchronous to clk_sys; link clock well below it
// Notes: stored stream arrives in address order as words over fill_*
`include "scp_params.svh"

// Notes on behaviour
// R1: address advances on serial clock rise only while select and enable active
// R2: data output released when select or output enable is inactive
// R3: at reset level, address held at start and data output released
// R4: reset/enable pin polarity selectable high or low; one variant high only
// R5: select high stops counting, releases data, enters standby
// R6: cascade output low only when enabled and address passed terminal count
// R7: after full readout cascade output follows select while enable stays active
// R8: enable inactive holds cascade output high until next reset
// R9: addressed bit presented shortly after each rising serial clock edge
// R10: reader makes the clock, gives exact pulses, then drops the enables
// R11: for slave readers an outside source clocks memory and reader alike
// R12: cascade output feeds next select; clock and data lines shared
// R13: edge after last bit drives cascade output low and releases data
// R14: reset level returns pointer to first bit so readout restarts
// R15: polarity comes from a fixed configuration bit, sampled continuously
module scp_reader #(
    parameter int MEM_BITS = `SCP_MEM_BITS,
    parameter int WORD_W = `SCP_WORD_W,
    parameter int FIFO_DEPTH = `SCP_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic srst,
    input scp_pkg::scp_pins_s pins,
    output logic data_out,
    output logic data_oe,
    output logic cascade_select_out,
    output logic standby,
    input wire logic fill_valid,
    input wire logic [WORD_W-1:0] fill_data,
    output logic fill_ready,
    output logic rewind
);
    import scp_pkg::*;

    localparam int AW = $clog2(MEM_BITS + 1);
    localparam int BW = $clog2(WORD_W + 1);
    localparam logic [AW-1:0] LAST_ADDRESS_COUNT = AW'(MEM_BITS - 1);
    localparam int NP = `SCP_PIN_COUNT;
    // select inactive and reset level: no false select or edge after srst
    localparam logic [NP-1:0] PIN_IDLE = NP'(1 << `SCP_PIN_CE);

    function automatic logic at_reset_level(input logic pin,
                                            input logic pol_high);
        return pol_high ? pin : ~pin;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // three-stage synchronisers; a change counts once stages 2 and 3 agree
    logic [NP-1:0] raw;
    logic [NP-1:0] sync1;
    logic [NP-1:0] sync2;
    logic [NP-1:0] sync3;
    logic [NP-1:0] pin_q;
    logic [NP-1:0] next_pin_q;
    logic clk_prev;

    assign raw[`SCP_PIN_CLK] = pins.link_clk;
    assign raw[`SCP_PIN_CE] = pins.chip_sel_n;
    assign raw[`SCP_PIN_RST] = pins.reset_oe;
    assign raw[`SCP_PIN_POL] = pins.reset_pol_high;

    always_comb
    begin
        for (int i = 0; i < NP; i++)
        begin
            next_pin_q[i] = (sync2[i] == sync3[i]) ? sync3[i] : pin_q[i];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            sync1 <= PIN_IDLE;
            sync2 <= PIN_IDLE;
            sync3 <= PIN_IDLE;
            pin_q <= PIN_IDLE;
            clk_prev <= 1'b0;
        end
        else
        begin
            sync1 <= raw;
            sync2 <= sync1;
            sync3 <= sync2;
            pin_q <= next_pin_q;
            clk_prev <= pin_q[`SCP_PIN_CLK];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // buffer between backing store and bit shifter
    logic word_valid;
    logic [WORD_W-1:0] word_data;
    logic word_take;
    logic flush;

    scp_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .srst(srst),
        .flush(flush),
        .in_valid(fill_valid),
        .in_data(fill_data),
        .in_ready(fill_ready),
        .out_valid(word_valid),
        .out_data(word_data),
        .out_ready(word_take)
    );

    ////////////////////////////////////////////////////////////////////////
    // pin decode shared by the groups below
    scp_state_e state;
    logic [AW-1:0] addr;
    logic reset_lvl;
    logic ce_act;
    logic oe_act;
    logic clk_rise;
    logic shift_now;
    logic last_bit;

    always_comb
    begin
        // polarity bit read every cycle, never latched
        reset_lvl = at_reset_level(pin_q[`SCP_PIN_RST],
                                   pin_q[`SCP_PIN_POL]); // [R4] [R15]
        oe_act = ~reset_lvl;
        ce_act = ~pin_q[`SCP_PIN_CE];
        clk_rise = pin_q[`SCP_PIN_CLK] & ~clk_prev;
        // limitation: a link edge while fetching is not counted
        shift_now = clk_rise & ce_act & oe_act & (state == ST_SEND); // [R1] [R5]
        last_bit = addr == LAST_ADDRESS_COUNT;
    end

    ////////////////////////////////////////////////////////////////////////
    // address counter and end-of-stream flag
    logic [AW-1:0] next_addr;
    logic done;
    logic next_done;

    always_comb
    begin
        next_addr = addr;
        next_done = done;
        if (reset_lvl)
        begin
            next_addr = '0; // [R3] [R14]
            next_done = 1'b0;
        end
        else if (shift_now)
        begin
            next_addr = AW'(addr + 1'b1);
            if (last_bit)
            begin
                next_done = 1'b1; // [R13]
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            addr <= '0;
            done <= 1'b0;
        end
        else
        begin
            addr <= next_addr;
            done <= next_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // word fetch and bit shifter
    scp_state_e next_state;
    logic [WORD_W-1:0] shreg;
    logic [WORD_W-1:0] next_shreg;
    logic [BW-1:0] bits_left;
    logic [BW-1:0] next_bits_left;

    always_comb
    begin
        next_state = state;
        next_shreg = shreg;
        next_bits_left = bits_left;
        word_take = 1'b0;
        flush = 1'b0;
        if (reset_lvl)
        begin
            // stale words dropped; store restarts on rewind
            next_state = ST_HOLD;
            next_bits_left = '0;
            flush = 1'b1;
        end
        else
        begin
            case (state)
                ST_HOLD:
                begin
                    next_state = ST_FETCH;
                end
                ST_FETCH:
                begin
                    // fetch takes one cycle, far shorter than a link period
                    word_take = 1'b1;
                    if (word_valid)
                    begin
                        next_shreg = word_data;
                        next_bits_left = BW'(WORD_W);
                        next_state = ST_SEND;
                    end
                end
                ST_SEND:
                begin
                    if (shift_now)
                    begin
                        next_shreg = {shreg[WORD_W-2:0], 1'b0}; // [R9]
                        next_bits_left = BW'(bits_left - 1'b1);
                        if (last_bit)
                        begin
                            next_state = ST_DONE; // [R13]
                        end
                        else if (bits_left == BW'(1))
                        begin
                            next_state = ST_FETCH;
                        end
                    end
                end
                ST_DONE:
                begin
                    next_state = ST_DONE;
                end
                default:
                begin
                    next_state = ST_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            state <= ST_HOLD;
            shreg <= '0;
            bits_left <= '0;
        end
        else
        begin
            state <= next_state;
            shreg <= next_shreg;
            bits_left <= next_bits_left;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin outputs, each straight from a flop
    logic next_data_out;
    logic next_data_oe;
    logic next_cascade;
    logic next_standby;
    logic next_rewind;

    always_comb
    begin
        next_data_out = next_shreg[WORD_W-1];
        next_data_oe = ce_act & oe_act & ~next_done; // [R2] [R3] [R5] [R13]
        // enable loss is the reset level, so done clears and output stays high
        next_cascade = ~(ce_act & oe_act & next_done); // [R6] [R7] [R8]
        next_standby = ~ce_act; // [R5]
        next_rewind = reset_lvl; // [R14]
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            data_out <= 1'b0;
            data_oe <= 1'b0;
            cascade_select_out <= 1'b1;
            standby <= 1'b1;
            rewind <= 1'b1;
        end
        else
        begin
            data_out <= next_data_out;
            data_oe <= next_data_oe;
            cascade_select_out <= next_cascade;
            standby <= next_standby;
            rewind <= next_rewind;
        end
    end

endmodule // scp_reader

// ===== scp_reader_properties.sv
// Purpose: port checks for scp_reader
// Assumes: pin changes reach outputs within 8 edges
// Notes: 8-cycle holds absorb the pin synchronisers
module scp_reader_properties #(
    parameter int MEM_BITS = 65536,
    parameter int WORD_W = 8,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire scp_pkg::scp_pins_s pins,
    input wire logic data_oe,
    input wire logic cascade_select_out,
    input wire logic standby,
    input wire logic rewind
);
    timeunit 1ns;
    timeprecision 1ps;
    import scp_pkg::*;
    logic rst_lvl;
    assign rst_lvl = pins.reset_oe == pins.reset_pol_high;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    ////////////////////////////////////////
    sequence s_rst_held; rst_lvl [*8]; endsequence
    sequence s_en_held; !rst_lvl [*8]; endsequence
    sequence s_sel_off; pins.chip_sel_n [*8]; endsequence
    sequence s_sel_on; !pins.chip_sel_n [*8]; endsequence
    a_reset_quiet: assert property (s_rst_held |-> rewind && !data_oe)
        else $error("reset level left data driven");
    a_reset_cascade: assert property (s_rst_held |-> cascade_select_out)
        else $error("cascade low at reset level");
    a_sel_off_quiet: assert property (s_sel_off |-> !data_oe && standby)
        else $error("deselected but driving or awake");
    a_sel_on_awake: assert property (s_sel_on |-> !standby)
        else $error("selected but in standby");
    a_cascade_follows: assert property (s_sel_off |-> cascade_select_out)
        else $error("cascade low while deselected");
    a_cascade_release: assert property ($fell(cascade_select_out) |-> !data_oe)
        else $error("cascade fell with data driven");
    a_cascade_excl: assert property (!(data_oe && !cascade_select_out))
        else $error("cascade low while data driven");
    a_enable_live: assert property (s_en_held |-> !rewind)
        else $error("rewind while enabled");
endmodule // scp_reader_properties

bind scp_reader scp_reader_properties #(.MEM_BITS(MEM_BITS),
    .WORD_W(WORD_W), .FIFO_DEPTH(FIFO_DEPTH)) u_props (
    .clk_sys(clk_sys), .srst(srst), .pins(pins), .data_oe(data_oe),
    .cascade_select_out(cascade_select_out), .standby(standby),
    .rewind(rewind));

// ===== scp_master_model.sv
// Purpose: master-mode reader at the far end of the link
// Assumes: link period 160 ns; clock held low between frames
// Notes: released data line rests high (pull-up)
module scp_master_model (
    input wire logic data_out,
    input wire logic data_oe,
    input wire logic pol_high,
    output logic link_clk,
    output logic chip_sel_n,
    output logic reset_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic din;
    logic got [$];
    assign din = data_oe ? data_out : 1'b1;
    initial
    begin
        link_clk = 1'b0;
        chip_sel_n = 1'b1;
        reset_oe = 1'b1;
    end
    ////////////////////////////////////////
    task automatic enables(input logic sel, input logic en);
        chip_sel_n = !sel;
        reset_oe = en ^ pol_high;
    endtask
    // bit taken just before the rise that moves past it
    task automatic pulses(input int n);
        repeat (n)
        begin
            #80;
            got.push_back(din);
            link_clk = 1'b1;
            #80;
            link_clk = 1'b0;
        end
    endtask
endmodule // scp_master_model

// ===== test_scp_reader.sv
// Purpose: bench for scp_reader
// Assumes: MEM_BITS cut to 512 to keep the run short
// Notes: store words follow a fixed pattern
module test_scp_reader;
    timeunit 1ns;
    timeprecision 1ps;
    import scp_pkg::*;
    localparam int BITS = 512;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic pol = 1'b1;
    logic fill_valid = 1'b0;
    logic [7:0] fill_data = 8'h00;
    logic lclk, csn, roe, dout, doe, cso, stby, frdy, rew;
    scp_pins_s pins;
    int fail_count = 0, samples_checked = 0, wr = 0, cyc = 0;
    assign pins = '{lclk, csn, roe, pol};
    always #4 clk_sys = ~clk_sys;
    scp_reader #(.MEM_BITS(BITS)) u_dut (.clk_sys(clk_sys), .srst(srst),
        .pins(pins), .data_out(dout), .data_oe(doe),
        .cascade_select_out(cso), .standby(stby), .fill_valid(fill_valid),
        .fill_data(fill_data), .fill_ready(frdy), .rewind(rew));
    scp_master_model u_m (.data_out(dout), .data_oe(doe), .pol_high(pol),
        .link_clk(lclk), .chip_sel_n(csn), .reset_oe(roe));
    ////////////////////////////////////////
    function automatic logic [7:0] word(int i);
        return 8'(i * 29) ^ 8'hA5;
    endfunction
    // store restarts at word 0 on rewind, then pushes at full rate
    always @(posedge clk_sys)
    begin
        if (rew !== 1'b0)
            wr = 0;
        else if (fill_valid && frdy === 1'b1)
            wr++;
        #1;
        fill_valid = rew === 1'b0 && wr < BITS / 8;
        fill_data = word(wr);
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic read_cmp(input int n);
        logic [7:0] w;
        u_m.got.delete();
        u_m.pulses(n);
        for (int k = 0; k < n; k++)
        begin
            w = word(k / 8);
            chk(u_m.got[k], w[7 - k % 8]);
        end
        step(10);
    endtask
    task automatic t_fill();
        u_m.enables(1'b0, 1'b1);
        u_m.pulses(8);
        step(60);
        chk(frdy, 1'b0);
        chk(wr >= 32 && wr <= 34, 1'b1);
        chk({doe, stby}, 2'b01);
        $display("fill test done");
    endtask
    task automatic t_full();
        u_m.enables(1'b1, 1'b1);
        step(10);
        chk(stby, 1'b0);
        read_cmp(BITS);
        chk({doe, cso, frdy}, 3'b001);
        u_m.pulses(2);
        step(10);
        chk({doe, cso}, 2'b00);
        u_m.enables(1'b0, 1'b1);
        step(10);
        chk(cso, 1'b1);
        u_m.enables(1'b1, 1'b1);
        step(10);
        chk(cso, 1'b0);
        $display("full readout test done");
    endtask
    task automatic t_abort();
        u_m.enables(1'b1, 1'b0);
        step(10);
        chk({doe, cso, rew}, 3'b011);
        u_m.enables(1'b1, 1'b1);
        step(60);
        read_cmp(20);
        u_m.enables(1'b1, 1'b0);
        step(10);
        u_m.enables(1'b1, 1'b1);
        step(60);
        read_cmp(12);
        $display("abort test done");
    endtask
    // polarity is a fixed setting, so it changes only under reset
    task automatic t_pol();
        srst = 1'b1;
        pol = 1'b0;
        u_m.enables(1'b1, 1'b0);
        step(12);
        srst = 1'b0;
        step(10);
        chk({roe, rew}, 2'b01);
        u_m.enables(1'b1, 1'b1);
        step(60);
        read_cmp(16);
        $display("polarity test done");
    endtask
    task automatic conclude();
        $display("checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            $display("unexpected %0t: run timed out", $time);
            fail_count++;
            conclude();
        end
    end
    initial
    begin
        step(12);
        srst = 1'b0;
        step(10);
        t_fill();
        t_full();
        t_abort();
        t_pol();
        conclude();
    end
endmodule // test_scp_reader
